// >>> verilog/vof_pkg.sv
package vof_pkg;
	localparam int unsigned ADDR_W = 7;
	localparam int unsigned DATA_W = 8;
	localparam logic [6:0] ADDR_OUT_SEL = 7'h46;
	localparam logic [6:0] ADDR_FLT_CTL = 7'h47;
	localparam logic [6:0] ADDR_RO_LO   = 7'h19;
	localparam logic [6:0] ADDR_RO_HI   = 7'h2c;
	localparam logic [6:0] ADDR_TEST_LO = 7'h1a;
	localparam logic [6:0] ADDR_TEST_HI = 7'h2c;
	localparam logic [7:0] RST_OUT_SEL  = 8'h04;
	localparam logic [7:0] RST_FLT_CTL  = 8'h00;
	localparam logic [7:0] MASK_OUT_SEL = 8'h1c;
	localparam logic [7:0] MASK_FLT_CTL = 8'hf8;
	localparam int unsigned POS_DRDY_MASK = 4;
	localparam int unsigned POS_SRC_LO    = 2;
	localparam int unsigned POS_FLT_SEL   = 7;
	localparam int unsigned POS_AVG_LO    = 3;
	localparam logic [1:0] SRC_FINAL   = 2'h0;
	localparam logic [1:0] SRC_DEC2    = 2'h1;
	localparam logic [1:0] SRC_DECHOP  = 2'h2;
	localparam logic [1:0] SRC_DEC1    = 2'h3;
	typedef struct packed {
		logic [7:0] out_sel;
		logic [7:0] flt_ctl;
		logic       lock;
	} vof_regs_type;
	typedef struct packed {
		logic        drdy_irq;
		logic [15:0] out_word;
		logic [7:0]  rdata;
		logic        wr_blocked;
	} vof_state_type;
endpackage : vof_pkg

// >>> verilog/vof_if.sv
`timescale 1ns/100ps
`default_nettype none
interface vof_if;
	logic       wr_en;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] out_sel;
	logic [7:0] flt_ctl;
	logic       lock;
	modport regs (input wr_en, addr, wdata, output out_sel, flt_ctl, lock);
	modport user (output wr_en, addr, wdata, input out_sel, flt_ctl, lock);
endinterface : vof_if
`default_nettype wire

// >>> verilog/vof_regs.sv
`timescale 1ns/100ps
`default_nettype none
module vof_regs (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// one-time lock level, already synchronised
	input wire logic lock_sync,
	// register carrier
	vof_if.regs      bus
);
	vof_pkg::vof_regs_type regs_ff;
	vof_pkg::vof_regs_type nxt_regs;

	always_comb begin
		nxt_regs = regs_ff;
		nxt_regs.lock = lock_sync;
		if (bus.wr_en) begin
			if (bus.addr == vof_pkg::ADDR_OUT_SEL) begin
				nxt_regs.out_sel = bus.wdata & vof_pkg::MASK_OUT_SEL;
			end
			if (bus.addr == vof_pkg::ADDR_FLT_CTL) begin
				nxt_regs.flt_ctl = bus.wdata & vof_pkg::MASK_FLT_CTL;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			regs_ff.out_sel <= vof_pkg::RST_OUT_SEL;
			regs_ff.flt_ctl <= vof_pkg::RST_FLT_CTL;
			regs_ff.lock    <= 1'b1;
		end else begin
			regs_ff <= nxt_regs;
		end
	end

	assign bus.out_sel = regs_ff.out_sel;
	assign bus.flt_ctl = regs_ff.flt_ctl;
	assign bus.lock    = regs_ff.lock;
endmodule : vof_regs
`default_nettype wire

// >>> verilog/vof_top.sv
// Functional notes
// - bit 4 of the output-select register masks the data-ready interrupt when 1, reset 0.
// - bits 3:2 of the output-select register pick the output word source, reset 01.
// - bit 7 of the filter register picks FIR (0) or moving average (1), reset 0.
// - bits 6:3 of the filter register give the moving-average sample count, 0000 bypass.
// - registers 0x19 through 0x2c are read-only and writes to them are ignored.
// - writes to test registers 0x1a through 0x2c are blocked while the lock bit is set.
// - output-select resets to 0x04 and filter control to 0x00, both read/write.
`timescale 1ns/100ps
`default_nettype none
module vof_top (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// register access
	input  wire logic        reg_wr,
	input  wire logic [6:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             reg_wr_blocked,
	// factory lock level from fuse
	input  wire logic        otp_lock,
	// filter path
	input  wire logic        drdy_in,
	input  wire logic [15:0] fir_word,
	input  wire logic [15:0] avg_word,
	input  wire logic [15:0] dec2_word,
	input  wire logic [15:0] dechop_word,
	input  wire logic [15:0] dec1_word,
	output logic      [15:0] out_word,
	output logic             avg_select,
	output logic      [3:0]  avg_count,
	output logic             drdy_irq
);
	vof_if bus ();
	logic lock_meta_ff;
	logic lock_sync_ff;
	vof_pkg::vof_state_type st_ff;
	vof_pkg::vof_state_type nxt_st;
	logic in_ro;
	logic in_test;
	logic [15:0] final_word;

	// fuse level is asynchronous to core_clk
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			lock_meta_ff <= 1'b1;
			lock_sync_ff <= 1'b1;
		end else begin
			lock_meta_ff <= otp_lock;
			lock_sync_ff <= lock_meta_ff;
		end
	end

	assign in_ro   = (reg_addr >= vof_pkg::ADDR_RO_LO) && (reg_addr <= vof_pkg::ADDR_RO_HI);
	assign in_test = (reg_addr >= vof_pkg::ADDR_TEST_LO) && (reg_addr <= vof_pkg::ADDR_TEST_HI);

	// read-only window never reaches the register file
	assign bus.wr_en = reg_wr && !in_ro;
	assign bus.addr  = reg_addr;
	assign bus.wdata = reg_wdata;

	vof_regs u_regs (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.lock_sync (lock_sync_ff),
		.bus       (bus)
	);

	assign final_word = bus.flt_ctl[vof_pkg::POS_FLT_SEL] ? avg_word : fir_word;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.drdy_irq = drdy_in && !bus.out_sel[vof_pkg::POS_DRDY_MASK];
		case (bus.out_sel[vof_pkg::POS_SRC_LO +: 2])
			vof_pkg::SRC_FINAL:  nxt_st.out_word = final_word;
			vof_pkg::SRC_DEC2:   nxt_st.out_word = dec2_word;
			vof_pkg::SRC_DECHOP: nxt_st.out_word = dechop_word;
			vof_pkg::SRC_DEC1:   nxt_st.out_word = dec1_word;
			default:             nxt_st.out_word = dec2_word;
		endcase
		// test window is inside the read-only window, flag reports the lock reason
		nxt_st.wr_blocked = reg_wr && in_test && bus.lock;
		case (reg_addr)
			vof_pkg::ADDR_OUT_SEL: nxt_st.rdata = bus.out_sel;
			vof_pkg::ADDR_FLT_CTL: nxt_st.rdata = bus.flt_ctl;
			default:               nxt_st.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata      = st_ff.rdata;
	assign reg_wr_blocked = st_ff.wr_blocked;
	assign out_word       = st_ff.out_word;
	assign drdy_irq       = st_ff.drdy_irq;
	assign avg_select     = bus.flt_ctl[vof_pkg::POS_FLT_SEL];
	assign avg_count      = bus.flt_ctl[vof_pkg::POS_AVG_LO +: 4];
endmodule : vof_top
`default_nettype wire

// >>> sim/vof_chk.sv
`timescale 1ns/100ps
`default_nettype none
module vof_chk (
	input wire logic       core_clk,
	input wire logic       resetn,
	input wire logic       reg_wr,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_wr_blocked,
	input wire logic       otp_lock,
	input wire logic       drdy_in,
	input wire logic       avg_select,
	input wire logic [3:0] avg_count,
	input wire logic       drdy_irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	wire logic wf = reg_wr && reg_addr == 7'h47;
	wire logic wt = reg_wr && reg_addr >= 7'h1a && reg_addr <= 7'h2c;
	property p_irq; drdy_irq |-> $past(drdy_in); endproperty
	a_irq: assert property (p_irq) else $error("irq without ready");
	property p_rst; $rose(resetn) |-> !avg_select && avg_count == 4'h0; endproperty
	a_rst: assert property (p_rst) else $error("filter reset value");
	property p_fw; wf |=> {avg_select, avg_count} == $past(reg_wdata[7:3]); endproperty
	a_fw: assert property (p_fw) else $error("filter write lost");
	property p_fh; !wf |=> $stable({avg_select, avg_count}); endproperty
	a_fh: assert property (p_fh) else $error("filter changed unasked");
	property p_rd; reg_addr == 7'h47 && !reg_wr |=> reg_rdata == {avg_select, avg_count, 3'h0};
	endproperty
	a_rd: assert property (p_rd) else $error("filter readback");
	property p_rs; reg_addr == 7'h46 |=> reg_rdata[7:5] == 3'h0 && reg_rdata[1:0] == 2'h0;
	endproperty
	a_rs: assert property (p_rs) else $error("reserved bits set");
	// lock passes two sync flops plus the register copy, so four steady samples are needed
	property p_bk; otp_lock [*4] ##0 wt |=> reg_wr_blocked; endproperty
	a_bk: assert property (p_bk) else $error("locked write not flagged");
	property p_bs; reg_wr_blocked |-> $past(wt); endproperty
	a_bs: assert property (p_bs) else $error("spurious block flag");
endmodule : vof_chk
bind vof_top vof_chk chk_i (.*);
`default_nettype wire

// >>> sim/vof_host.sv
`timescale 1ns/100ps
`default_nettype none
module vof_host (
	input  wire logic       core_clk,
	input  wire logic [7:0] reg_rdata,
	output logic            reg_wr = 1'b0,
	output logic      [6:0] reg_addr = 7'h00,
	output logic      [7:0] reg_wdata = 8'h00
);
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		@(posedge core_clk) #1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		@(posedge core_clk) #1;
		reg_wr = 1'b0;
		reg_wdata = ~v; // released data must not look valid
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [7:0] v);
		@(posedge core_clk) #1;
		reg_addr = a;
		@(posedge core_clk) #1;
		v = reg_rdata;
	endtask : rd
endmodule : vof_host
`default_nettype wire

// >>> sim/vof_bench.sv
`timescale 1ns/100ps
`default_nettype none
module vof_bench;
	logic        core_clk, resetn, otp_lock, drdy_in, reg_wr, reg_wr_blocked, avg_select, drdy_irq;
	logic [6:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, d;
	logic [3:0]  avg_count;
	logic [15:0] out_word, w[5] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555};
	logic [3:0]  c[5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
	int          mismatches = 0, n_tests = 0;
	vof_host h (.*);
	vof_top dut (.fir_word(w[0]), .dec2_word(w[1]), .dechop_word(w[2]), .dec1_word(w[3]),
		.avg_word(w[4]), .*);
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic chk(string n, logic [15:0] e, logic [15:0] s);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wrap_up;
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	task automatic t_reset;
		h.rd(7'h46, d);
		chk("sel", 16'h0004, d);
		h.rd(7'h47, d);
		chk("flt", 16'h0000, d);
		chk("word", w[1], out_word);
		chk("irq", 16'h1, drdy_irq);
	endtask : t_reset
	task automatic t_src;
		for (int i = 0; i < 4; i++) begin
			h.wr(7'h46, 8'he3 | 8'(i << 2));
			h.rd(7'h46, d);
			chk("sel", 16'(i << 2), d);
			chk("word", w[i], out_word);
		end
		h.wr(7'h46, 8'h10);
		h.rd(7'h46, d);
		chk("irq", 16'h0, drdy_irq);
		h.wr(7'h46, 8'h00);
		drdy_in = 1'b0;
		h.rd(7'h46, d);
		chk("irq", 16'h0, drdy_irq);
		drdy_in = 1'b1;
		h.rd(7'h46, d);
		chk("irq", 16'h1, drdy_irq);
	endtask : t_src
	task automatic t_flt;
		for (int i = 0; i < 5; i++) begin
			h.wr(7'h47, {1'b1, c[i], 3'h7});
			h.rd(7'h47, d);
			chk("flt", {8'h00, 1'b1, c[i], 3'h0}, d);
			chk("cnt", c[i], avg_count);
			chk("avg", w[4], out_word);
			chk("fsel", 16'h1, avg_select);
		end
		h.wr(7'h47, 8'h00);
		h.rd(7'h47, d);
		chk("fir", w[0], out_word);
		chk("fsel", 16'h0, avg_select);
	endtask : t_flt
	task automatic t_lock;
		h.wr(7'h2c, 8'h55);
		chk("blk", 16'h1, reg_wr_blocked);
		otp_lock = 1'b0;
		repeat (3) @(posedge core_clk);
		h.wr(7'h1a, 8'h55);
		chk("blk", 16'h0, reg_wr_blocked);
		h.rd(7'h1a, d);
		chk("ro", 16'h0, d);
		h.rd(7'h47, d);
		chk("flt", 16'h0, d);
	endtask : t_lock
	initial begin
		resetn = 1'b0;
		otp_lock = 1'b1;
		drdy_in = 1'b1;
		repeat (8) @(posedge core_clk);
		#1 resetn = 1'b1;
		t_reset();
		t_src();
		t_flt();
		t_lock();
		wrap_up();
	end
	initial begin
		#40000;
		mismatches++;
		wrap_up();
	end
endmodule : vof_bench
`default_nettype wire
